// ---- design/fdccmd_pkg.sv ----
// Constants for the drive-control command interpreter of a floppy controller.
// Assumes a 50 MHz system clock and a plain address/strobe register port.
// Functional notes
// R1: Drive status query returns status 3 immediately.
// R2: Head unloads after programmed delay post-transfer.
// R3: Step pulses spaced by programmed step interval.
// R4: Transfer starts after programmed head load delay.
// R5: Delays scale with data rate, FM/MFM alike.
// R6: Select bit one means non-DMA transfers.
// R7: DMA uses request pin; else flag plus interrupt.
// R8: Implied seek precedes read/write when enabled.
// R9: FIFO disabled by default, byte-wise requests.
// R10: Polling raises exactly one interrupt after reset.
// R11: No polling while head loaded, unload pending.
// R12: FIFO threshold is code plus one bytes.
// R13: Precompensation starts at programmed track, default 0.
// R14: Version query returns one fixed identity byte.
// R15: Relative seek direction: 0 out, 1 in.
// R16: Relative seek issues exactly count steps.
// R17: Inward relative seek wraps cylinder modulo 256.
// R18: Only one relative seek active at once.
// R19: Stepping out past track 0 sets fault.
// R20: Recalibrate watches track zero, 80 steps max.
// R21: Host computes signed track difference itself.
// R22: Relative seek decoded like seek, top bits.
// R23: Interrupt when seek, relative seek, recalibrate finish.
// R24: Timers run from rate-dependent time base.
// R25: Outward relative step decrements present cylinder.
package fdccmd_pkg;

  // Timing
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned UNIT_US = 500;
  localparam int unsigned UNIT_CYC_1M = UNIT_US * CLK_MHZ;
  localparam int unsigned STEP_PULSE_US = 1;
  localparam logic [5:0] STEP_PULSE_CYC = 6'(STEP_PULSE_US * CLK_MHZ);
  localparam logic [6:0] RECAL_MAX_STEPS = 7'h50;

  // Register port offsets
  localparam logic [1:0] ADDR_DATA = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_RATE = 2'h2;

  // Opcodes
  localparam logic [7:0] OP_SPECIFY = 8'h03;
  localparam logic [7:0] OP_SENSE_DRV = 8'h04;
  localparam logic [7:0] OP_RECAL = 8'h07;
  localparam logic [7:0] OP_SENSE_INT = 8'h08;
  localparam logic [5:0] OP_SEEK_LOW = 6'h0F;
  localparam logic [7:0] OP_VERSION = 8'h10;
  localparam logic [7:0] OP_CONFIGURE = 8'h13;
  localparam int REL_BIT = 7;
  localparam int DIR_BIT = 6;

  // Data rate codes
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [1:0] RATE_1M = 2'h3;
  localparam logic [1:0] RATE_RESET = RATE_500K;

  // Status 0 fields
  localparam int ST0_IC_POS = 6;
  localparam int ST0_SE_BIT = 5;
  localparam int ST0_EC_BIT = 4;
  localparam logic [1:0] IC_NORMAL = 2'h0;
  localparam logic [1:0] IC_ABNORMAL = 2'h1;
  localparam logic [1:0] IC_POLL = 2'h3;
  localparam logic [7:0] ST0_INVALID = 8'h80;

  // Status 3 fields
  localparam int ST3_WP_BIT = 6;
  localparam int ST3_RDY_BIT = 5;
  localparam int ST3_T0_BIT = 4;
  localparam int ST3_TS_BIT = 3;
  localparam int ST3_HD_BIT = 2;

  // Main status fields
  localparam int MSR_RQM_BIT = 7;
  localparam int MSR_DIO_BIT = 6;
  localparam int MSR_NDMA_BIT = 5;
  localparam int MSR_BUSY_BIT = 4;
  localparam int MSR_SEEK_BIT = 0;

  // Command byte fields
  localparam int SPEC_SRT_POS = 4;
  localparam int SPEC_HUT_POS = 0;
  localparam int SPEC_HLT_POS = 1;
  localparam int SPEC_ND_BIT = 0;
  localparam int CFG_EIS_BIT = 6;
  localparam int CFG_FIFO_DIS_BIT = 5;
  localparam int CFG_POLL_OFF_BIT = 4;
  localparam int CFG_THR_POS = 0;

  // Reset values
  localparam logic [3:0] SRT_RESET = 4'h0;
  localparam logic [3:0] HUT_RESET = 4'h0;
  localparam logic [6:0] HLT_RESET = 7'h00;
  localparam logic ND_RESET = 1'b0;
  localparam logic EIS_RESET = 1'b0;
  localparam logic FIFO_DIS_RESET = 1'b1;
  localparam logic POLL_OFF_RESET = 1'b0;
  localparam logic [3:0] THR_RESET = 4'h0;
  localparam logic [7:0] PRECOMP_START_TRACK_RESET = 8'h00;

  // Delay codes in half-millisecond units at the 1M rate
  localparam logic [8:0] HUT_ZERO_UNITS = 9'h100;
  localparam logic [8:0] HLT_ZERO_UNITS = 9'h100;
  localparam logic [8:0] SRT_ZERO_UNITS = 9'h010;

  typedef enum logic [1:0] {
    PH_CMD = 2'b00,
    PH_EXEC = 2'b01,
    PH_RES = 2'b10
  } fdccmd_phase_e;

  typedef enum logic [1:0] {
    SK_IDLE = 2'b00,
    SK_CHECK = 2'b01,
    SK_PULSE = 2'b10,
    SK_GAP = 2'b11
  } fdccmd_step_e;

  typedef enum logic [1:0] {
    SM_SEEK = 2'b00,
    SM_REL = 2'b01,
    SM_RECAL = 2'b10,
    SM_IMPLIED = 2'b11
  } fdccmd_mode_e;

  typedef enum logic [2:0] {
    HL_IDLE = 3'b000,
    HL_SEEKREQ = 3'b001,
    HL_SEEKWAIT = 3'b010,
    HL_LOAD = 3'b011,
    HL_LOADWAIT = 3'b100,
    HL_XFER = 3'b101
  } fdccmd_head_e;

endpackage : fdccmd_pkg

// ---- design/fdccmd_delay_timer.sv ----
// One-shot delay timer counting whole time-base units.
// Assumes a unit length in system clocks that stays stable while it runs.
`timescale 1ns/1ps
module fdccmd_delay_timer (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  input wire logic cancel_i,
  input wire logic [8:0] units_i,
  input wire logic [19:0] unit_cyc_i,
  // Status
  output logic busy_o,
  output logic done_o
);

  logic [19:0] pre_ff;
  logic [8:0] left_ff;
  logic busy_ff;
  logic done_ff;

  // Prescaler restarts on start so no unit is ever cut short
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pre_ff <= 20'h00000;
      left_ff <= 9'h000;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (cancel_i) begin
        busy_ff <= 1'b0;
      end else if (start_i) begin
        busy_ff <= 1'b1;
        pre_ff <= 20'h00000;
        left_ff <= (units_i == 9'h000) ? 9'h001 : units_i;
      end else if (busy_ff) begin
        if (pre_ff >= unit_cyc_i - 20'h00001) begin
          pre_ff <= 20'h00000;
          if (left_ff == 9'h001) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
          end else begin
            left_ff <= left_ff - 9'h001;
          end
        end else begin
          pre_ff <= pre_ff + 20'h00001;
        end
      end
    end
  end

  assign busy_o = busy_ff;
  assign done_o = done_ff;

endmodule : fdccmd_delay_timer

// ---- design/fdccmd_top.sv ----
// Drive-control command interpreter: specify, configure, version, drive status,
// seek, relative seek, recalibrate, interrupt status, head load/unload timing.
// Assumes a data path that reports read/write commands and transfer requests
// on the same clock, and drive pins that arrive asynchronously.
`timescale 1ns/1ps
module fdccmd_top #(
  parameter int unsigned UNIT_CYC_1M = fdccmd_pkg::UNIT_CYC_1M,
  parameter logic [7:0] VERSION_ID = 8'hA5 // Arbitrary identity value
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rd_data_o,
  // Data path hand-off
  input wire logic rw_cmd_i,
  input wire logic [7:0] rw_cyl_i,
  input wire logic rw_end_i,
  input wire logic xfer_req_i,
  output logic rw_go_o,
  output logic dma_request_pin_o,
  output logic no_dma_select_o,
  output logic fifo_disable_o,
  output logic [4:0] fifo_threshold_o,
  output logic precomp_active_o,
  output logic controller_interrupt_pin_o,
  // Drive pins
  input wire logic track_zero_sense_i,
  input wire logic write_protect_i,
  input wire logic drive_ready_i,
  input wire logic two_sided_i,
  output logic step_o,
  output logic step_heading_in_o,
  output logic head_load_o,
  output logic [1:0] drive_sel_o
);
  import fdccmd_pkg::*;

  // Command bytes needed for each opcode
  function automatic logic [2:0] cmd_len(input logic [7:0] op);
    if (op[5:0] == OP_SEEK_LOW) begin
      cmd_len = 3'h3; // [R22]
    end else begin
      case (op)
        OP_SPECIFY: cmd_len = 3'h3;
        OP_SENSE_DRV: cmd_len = 3'h2;
        OP_RECAL: cmd_len = 3'h2;
        OP_CONFIGURE: cmd_len = 3'h4;
        default: cmd_len = 3'h1;
      endcase
    end
  endfunction : cmd_len

  // Clocks per time-base unit for the selected data rate
  function automatic logic [19:0] unit_cyc(input logic [1:0] rate);
    case (rate)
      RATE_1M: unit_cyc = 20'(UNIT_CYC_1M);
      RATE_500K: unit_cyc = 20'(UNIT_CYC_1M * 2);
      RATE_300K: unit_cyc = 20'((UNIT_CYC_1M * 10) / 3);
      default: unit_cyc = 20'(UNIT_CYC_1M * 4);
    endcase
  endfunction : unit_cyc

  // Synchronisers for drive pins
  logic [3:0] pin_a_ff;
  logic [3:0] pin_b_ff;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_a_ff <= 4'h0;
      pin_b_ff <= 4'h0;
    end else begin
      pin_a_ff <= {two_sided_i, drive_ready_i, write_protect_i, track_zero_sense_i};
      pin_b_ff <= pin_a_ff;
    end
  end
  logic trk0;
  assign trk0 = pin_b_ff[0];

  // State
  fdccmd_phase_e phase_ff;
  fdccmd_step_e sk_state_ff;
  fdccmd_mode_e sk_mode_ff;
  fdccmd_head_e hl_state_ff;
  logic [7:0] cmd_ff [0:3];
  logic [2:0] cmd_cnt_ff;
  logic [7:0] res_ff [0:1];
  logic res_idx_ff;
  logic res_last_ff;
  logic [7:0] rd_data_ff;
  logic [1:0] rate_ff;
  logic [3:0] srt_ff;
  logic [3:0] hut_ff;
  logic [6:0] hlt_ff;
  logic nd_ff;
  logic eis_ff;
  logic fifo_dis_ff;
  logic poll_off_ff;
  logic [3:0] thr_ff;
  logic [7:0] precomp_start_track_ff;
  logic [7:0] pcn_ff;
  logic [7:0] sk_target_ff;
  logic sk_dir_ff;
  logic [6:0] sk_steps_ff;
  logic [5:0] pulse_cnt_ff;
  logic step_ff;
  logic [1:0] drive_ff;
  logic head_ff;
  logic [7:0] st0_ff;
  logic int_ff;
  logic poll_pend_ff;
  logic head_load_ff;
  logic rw_go_ff;
  logic [7:0] rw_cyl_ff;
  logic dma_req_ff;

  // Decode of the command in execution
  logic exec;
  logic [7:0] op;
  logic is_seek_cmd;
  logic sk_idle;
  logic cmd_sk_start;
  logic cmd_sk_refuse;
  logic imp_sk_start;
  logic sk_done;
  logic sk_fault;
  logic [19:0] cyc_per_unit;
  assign exec = (phase_ff == PH_EXEC);
  assign op = cmd_ff[0];
  assign is_seek_cmd = (op[5:0] == OP_SEEK_LOW) || (op == OP_RECAL);
  assign sk_idle = (sk_state_ff == SK_IDLE);
  // A seek, relative seek or recalibrate is refused while the single stepper runs; an implied seek waits
  assign cmd_sk_start = exec && is_seek_cmd && sk_idle;
  assign cmd_sk_refuse = exec && is_seek_cmd && !sk_idle; // [R18]
  assign imp_sk_start = (hl_state_ff == HL_SEEKREQ) && sk_idle && !cmd_sk_start;
  assign cyc_per_unit = unit_cyc(rate_ff); // [R5] [R24]

  // Delay timers: step gap, head load, head unload
  logic gap_done;
  logic load_done;
  logic unload_busy;
  logic unload_done;
  fdccmd_delay_timer u_gap (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .start_i(sk_state_ff == SK_PULSE && pulse_cnt_ff == STEP_PULSE_CYC),
    .cancel_i(1'b0),
    .units_i(SRT_ZERO_UNITS - {5'h00, srt_ff}), // [R3]
    .unit_cyc_i(cyc_per_unit),
    .busy_o(),
    .done_o(gap_done)
  );
  fdccmd_delay_timer u_load (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .start_i(hl_state_ff == HL_LOAD && !head_load_ff),
    .cancel_i(1'b0),
    .units_i((hlt_ff == 7'h00) ? HLT_ZERO_UNITS : {1'b0, hlt_ff, 1'b0}), // [R4]
    .unit_cyc_i(cyc_per_unit),
    .busy_o(),
    .done_o(load_done)
  );
  fdccmd_delay_timer u_unload (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .start_i(hl_state_ff == HL_XFER && rw_end_i),
    .cancel_i(rw_cmd_i),
    .units_i((hut_ff == 4'h0) ? HUT_ZERO_UNITS : {1'b0, hut_ff, 4'h0}), // [R2]
    .unit_cyc_i(cyc_per_unit),
    .busy_o(unload_busy),
    .done_o(unload_done)
  );

  // Command collection and result phase
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      phase_ff <= PH_CMD;
      cmd_cnt_ff <= 3'h0;
      res_idx_ff <= 1'b0;
      res_last_ff <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        cmd_ff[i] <= 8'h00;
      end
      res_ff[0] <= 8'h00;
      res_ff[1] <= 8'h00;
    end else begin
      case (phase_ff)
        PH_CMD: begin
          if (wr_i && addr_i == ADDR_DATA) begin
            cmd_ff[cmd_cnt_ff[1:0]] <= wr_data_i;
            if (cmd_cnt_ff + 3'h1 == cmd_len(cmd_cnt_ff == 3'h0 ? wr_data_i : cmd_ff[0])) begin
              phase_ff <= PH_EXEC;
              cmd_cnt_ff <= 3'h0;
            end else begin
              cmd_cnt_ff <= cmd_cnt_ff + 3'h1;
            end
          end
        end
        PH_EXEC: begin
          res_idx_ff <= 1'b0;
          res_last_ff <= 1'b1;
          phase_ff <= PH_RES;
          if (op == OP_SENSE_DRV) begin
            res_ff[0] <= {1'b0, pin_b_ff[1], pin_b_ff[2], pin_b_ff[0], pin_b_ff[3],
                          cmd_ff[1][2:0]}; // [R1]
          end else if (op == OP_VERSION) begin
            res_ff[0] <= VERSION_ID; // [R14]
          end else if (op == OP_SENSE_INT && int_ff) begin
            res_ff[0] <= st0_ff;
            res_ff[1] <= pcn_ff;
            res_last_ff <= 1'b0;
          end else if (op == OP_SPECIFY || op == OP_CONFIGURE || is_seek_cmd) begin
            phase_ff <= PH_CMD; // No result phase
          end else begin
            res_ff[0] <= ST0_INVALID;
          end
        end
        PH_RES: begin
          if (rd_i && addr_i == ADDR_DATA) begin
            res_idx_ff <= 1'b1;
            if (res_last_ff) begin
              phase_ff <= PH_CMD;
            end
            res_last_ff <= 1'b1;
          end
        end
        default: phase_ff <= PH_CMD;
      endcase
    end
  end

  // Specify and configure parameters
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      srt_ff <= SRT_RESET;
      hut_ff <= HUT_RESET;
      hlt_ff <= HLT_RESET;
      nd_ff <= ND_RESET;
      eis_ff <= EIS_RESET;
      fifo_dis_ff <= FIFO_DIS_RESET;
      poll_off_ff <= POLL_OFF_RESET;
      thr_ff <= THR_RESET;
      precomp_start_track_ff <= PRECOMP_START_TRACK_RESET;
    end else if (exec && op == OP_SPECIFY) begin
      srt_ff <= cmd_ff[1][SPEC_SRT_POS +: 4];
      hut_ff <= cmd_ff[1][SPEC_HUT_POS +: 4];
      hlt_ff <= cmd_ff[2][SPEC_HLT_POS +: 7];
      nd_ff <= cmd_ff[2][SPEC_ND_BIT]; // [R6]
    end else if (exec && op == OP_CONFIGURE) begin
      eis_ff <= cmd_ff[2][CFG_EIS_BIT]; // [R8]
      fifo_dis_ff <= cmd_ff[2][CFG_FIFO_DIS_BIT]; // [R9]
      poll_off_ff <= cmd_ff[2][CFG_POLL_OFF_BIT];
      thr_ff <= cmd_ff[2][CFG_THR_POS +: 4];
      precomp_start_track_ff <= cmd_ff[3]; // [R13]
    end
  end

  // Stepper shared by seek, relative seek, recalibrate and implied seek
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sk_state_ff <= SK_IDLE;
      sk_mode_ff <= SM_SEEK;
      sk_target_ff <= 8'h00;
      sk_dir_ff <= 1'b0;
      sk_steps_ff <= 7'h00;
      pulse_cnt_ff <= 6'h00;
      step_ff <= 1'b0;
      pcn_ff <= 8'h00;
      drive_ff <= 2'h0;
      head_ff <= 1'b0;
    end else begin
      case (sk_state_ff)
        SK_IDLE: begin
          sk_steps_ff <= 7'h00;
          if (cmd_sk_start) begin
            sk_state_ff <= SK_CHECK;
            drive_ff <= cmd_ff[1][1:0];
            head_ff <= cmd_ff[1][2];
            sk_target_ff <= cmd_ff[2];
            if (op == OP_RECAL) begin
              sk_mode_ff <= SM_RECAL;
              sk_dir_ff <= 1'b0;
              pcn_ff <= 8'h00;
            end else if (op[REL_BIT]) begin
              sk_mode_ff <= SM_REL;
              sk_dir_ff <= op[DIR_BIT]; // [R15]
            end else begin
              sk_mode_ff <= SM_SEEK;
            end
          end else if (imp_sk_start) begin
            sk_state_ff <= SK_CHECK;
            sk_mode_ff <= SM_IMPLIED;
            sk_target_ff <= rw_cyl_ff;
          end
        end
        SK_CHECK: begin
          sk_state_ff <= SK_PULSE;
          pulse_cnt_ff <= 6'h00;
          case (sk_mode_ff)
            SM_REL: begin
              // Count only; present cylinder is compared only with 0 when stepping out
              if (sk_target_ff == 8'h00 || (!sk_dir_ff && pcn_ff == 8'h00)) begin
                sk_state_ff <= SK_IDLE; // [R16] [R19]
              end
            end
            SM_RECAL: begin
              if (trk0 || sk_steps_ff == RECAL_MAX_STEPS) begin
                sk_state_ff <= SK_IDLE; // [R20]
              end
            end
            default: begin
              sk_dir_ff <= (sk_target_ff > pcn_ff);
              if (sk_target_ff == pcn_ff) begin
                sk_state_ff <= SK_IDLE;
              end
            end
          endcase
        end
        SK_PULSE: begin
          step_ff <= (pulse_cnt_ff != STEP_PULSE_CYC);
          pulse_cnt_ff <= pulse_cnt_ff + 6'h01;
          if (pulse_cnt_ff == STEP_PULSE_CYC) begin
            sk_state_ff <= SK_GAP;
            sk_steps_ff <= sk_steps_ff + 7'h01;
            if (sk_mode_ff == SM_REL) begin
              sk_target_ff <= sk_target_ff - 8'h01;
            end
            if (sk_mode_ff != SM_RECAL) begin
              // Wraps past 255 only when stepping in; stepping out never starts from 0
              pcn_ff <= sk_dir_ff ? pcn_ff + 8'h01 : pcn_ff - 8'h01; // [R17] [R25]
            end
          end
        end
        SK_GAP: begin
          if (gap_done) begin
            sk_state_ff <= SK_CHECK; // [R3]
          end
        end
        default: sk_state_ff <= SK_IDLE;
      endcase
    end
  end

  // Completion of the stepper, seen on the exit from the check state
  assign sk_done = (sk_state_ff == SK_CHECK) && (
    (sk_mode_ff == SM_REL && (sk_target_ff == 8'h00 || (!sk_dir_ff && pcn_ff == 8'h00))) ||
    (sk_mode_ff == SM_RECAL && (trk0 || sk_steps_ff == RECAL_MAX_STEPS)) ||
    ((sk_mode_ff == SM_SEEK || sk_mode_ff == SM_IMPLIED) && sk_target_ff == pcn_ff));
  assign sk_fault = (sk_mode_ff == SM_REL) ? (sk_target_ff != 8'h00)
                  : (sk_mode_ff == SM_RECAL) && !trk0;

  // Interrupt status; a new event wins over the clear by status sense
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st0_ff <= 8'h00;
      int_ff <= 1'b0;
      poll_pend_ff <= 1'b1;
    end else begin
      if (sk_done && sk_mode_ff != SM_IMPLIED) begin
        int_ff <= 1'b1; // [R23]
        st0_ff <= {sk_fault ? IC_ABNORMAL : IC_NORMAL, 1'b1, sk_fault, 1'b0, head_ff,
                   drive_ff}; // [R19] [R20]
      end else if (cmd_sk_refuse) begin
        int_ff <= 1'b1; // [R18]
        st0_ff <= {IC_ABNORMAL, 1'b1, 1'b0, 1'b0, cmd_ff[1][2:0]};
      end else if (poll_pend_ff && !head_load_ff && !poll_off_ff) begin
        int_ff <= 1'b1; // [R10] [R11]
        st0_ff <= {IC_POLL, 6'h00};
      end else if (exec && op == OP_SENSE_INT) begin
        int_ff <= 1'b0;
      end
      // Polling fires once per reset, or is dropped if switched off first
      if (!head_load_ff || poll_off_ff) begin
        poll_pend_ff <= 1'b0; // [R10]
      end
    end
  end

  // Head load, implied seek and head unload sequencing
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      hl_state_ff <= HL_IDLE;
      head_load_ff <= 1'b0;
      rw_go_ff <= 1'b0;
      rw_cyl_ff <= 8'h00;
    end else begin
      rw_go_ff <= 1'b0;
      if (unload_done) begin
        head_load_ff <= 1'b0; // [R2]
      end
      case (hl_state_ff)
        HL_IDLE: begin
          if (rw_cmd_i) begin
            rw_cyl_ff <= rw_cyl_i;
            hl_state_ff <= eis_ff ? HL_SEEKREQ : HL_LOAD; // [R8]
          end
        end
        HL_SEEKREQ: begin
          if (imp_sk_start) begin
            hl_state_ff <= HL_SEEKWAIT;
          end
        end
        HL_SEEKWAIT: begin
          if (sk_done) begin
            hl_state_ff <= HL_LOAD;
          end
        end
        HL_LOAD: begin
          // A head still loaded from the last transfer needs no new delay
          if (head_load_ff && !unload_done) begin
            rw_go_ff <= 1'b1;
            hl_state_ff <= HL_XFER;
          end else begin
            head_load_ff <= 1'b1;
            hl_state_ff <= HL_LOADWAIT;
          end
        end
        HL_LOADWAIT: begin
          if (load_done) begin
            rw_go_ff <= 1'b1; // [R4]
            hl_state_ff <= HL_XFER;
          end
        end
        HL_XFER: begin
          if (rw_end_i) begin
            hl_state_ff <= HL_IDLE; // [R2]
          end
        end
        default: hl_state_ff <= HL_IDLE;
      endcase
    end
  end

  // Register reads answered one cycle later; unmapped reads give zero
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_data_ff <= 8'h00;
      rate_ff <= RATE_RESET;
      dma_req_ff <= 1'b0;
    end else begin
      dma_req_ff <= !nd_ff && xfer_req_i && hl_state_ff == HL_XFER; // [R7]
      if (wr_i && addr_i == ADDR_RATE) begin
        rate_ff <= wr_data_i[1:0];
      end
      rd_data_ff <= 8'h00;
      if (rd_i) begin
        case (addr_i)
          ADDR_DATA: rd_data_ff <= (phase_ff == PH_RES) ? res_ff[res_idx_ff] : 8'h00;
          ADDR_STATUS: begin
            rd_data_ff[MSR_RQM_BIT] <= (phase_ff != PH_EXEC); // [R7]
            rd_data_ff[MSR_DIO_BIT] <= (phase_ff == PH_RES);
            rd_data_ff[MSR_NDMA_BIT] <= nd_ff && hl_state_ff == HL_XFER;
            rd_data_ff[MSR_BUSY_BIT] <= (phase_ff != PH_CMD) || (cmd_cnt_ff != 3'h0);
            rd_data_ff[MSR_SEEK_BIT] <= !sk_idle;
          end
          ADDR_RATE: rd_data_ff <= {6'h00, rate_ff};
          default: rd_data_ff <= 8'h00;
        endcase
      end
    end
  end

  // Outputs
  assign rd_data_o = rd_data_ff;
  assign rw_go_o = rw_go_ff;
  assign dma_request_pin_o = dma_req_ff;
  assign no_dma_select_o = nd_ff;
  assign fifo_disable_o = fifo_dis_ff;
  assign fifo_threshold_o = fifo_dis_ff ? 5'h01 : {1'b0, thr_ff} + 5'h01; // [R9] [R12]
  assign precomp_active_o = (pcn_ff >= precomp_start_track_ff); // [R13]
  // Non-DMA transfers also raise the interrupt pin
  assign controller_interrupt_pin_o = int_ff || (nd_ff && xfer_req_i && hl_state_ff == HL_XFER);
  assign step_o = step_ff;
  assign step_heading_in_o = sk_dir_ff;
  assign head_load_o = head_load_ff;
  assign drive_sel_o = drive_ff;

endmodule : fdccmd_top

// ---- dv/fdccmd_drive_model.sv ----
// Drive head mechanism seen through its stepper pins.
// Assumes step pulses well apart; the head stops at track 0.
`timescale 1ns/1ps
module fdccmd_drive_model #(parameter int START_TRK = 3) (
  // Stepper pins
  input wire logic step_i,
  input wire logic dir_i,
  // Sense pin
  output logic trk0_o
);
  int trk = START_TRK;
  // One track per pulse; the end stop blocks anything past track 0
  always @(posedge step_i) trk <= dir_i ? trk + 1 : (trk > 0 ? trk - 1 : 0);
  assign trk0_o = (trk == 0);
endmodule : fdccmd_drive_model

// ---- dv/fdccmd_top_sva.sv ----
// Port assertions for the command interpreter.
// Assumes UNIT_CYC_1M of at least 4, so a step gap lasts 4 cycles or more.
`timescale 1ns/1ps
module fdccmd_top_sva (
  // Watched ports
  input wire logic sys_clk_i, rst_i, rd_i, xfer_req_i, rw_go_o, head_load_o,
  input wire logic step_o, step_heading_in_o, dma_request_pin_o, no_dma_select_o,
  input wire logic fifo_disable_o,
  input wire logic [7:0] rd_data_o,
  input wire logic [4:0] fifo_threshold_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Pulse and gap shapes of the stepper
  sequence s_pulse; step_o [*8]; endsequence
  sequence s_gap; !step_o [*4]; endsequence
  property p_rd_idle; !$past(rd_i) |-> rd_data_o == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_width; $rose(step_o) |-> s_pulse; endproperty
  a_width: assert property (p_width) else $error("step pulse too short");
  property p_gap; $fell(step_o) |-> s_gap; endproperty
  a_gap: assert property (p_gap) else $error("step gap too short");
  property p_dir; step_o && $past(step_o) |-> $stable(step_heading_in_o); endproperty
  a_dir: assert property (p_dir) else $error("direction moved in pulse");
  property p_dma; dma_request_pin_o |-> $past(xfer_req_i) && !$past(no_dma_select_o); endproperty
  a_dma: assert property (p_dma) else $error("dma request without cause");
  property p_byte; fifo_disable_o |-> fifo_threshold_o == 5'h01; endproperty
  a_byte: assert property (p_byte) else $error("threshold not one byte");
  property p_thr; fifo_threshold_o inside {[5'h01:5'h10]}; endproperty
  a_thr: assert property (p_thr) else $error("threshold out of range");
  property p_go; rw_go_o |-> head_load_o; endproperty
  a_go: assert property (p_go) else $error("start with head unloaded");
endmodule : fdccmd_top_sva
bind fdccmd_top fdccmd_top_sva chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .rd_i(rd_i),
  .xfer_req_i(xfer_req_i), .rw_go_o(rw_go_o), .head_load_o(head_load_o), .step_o(step_o),
  .step_heading_in_o(step_heading_in_o), .dma_request_pin_o(dma_request_pin_o),
  .no_dma_select_o(no_dma_select_o), .fifo_disable_o(fifo_disable_o),
  .rd_data_o(rd_data_o), .fifo_threshold_o(fifo_threshold_o));

// ---- dv/fdccmd_top_tb.sv ----
// Self-checking bench for the drive-control command interpreter.
// Assumes the drive model on the stepper pins and the bound checker.
`timescale 1ns/1ps
module fdccmd_top_tb;
  import fdccmd_pkg::*;
  logic clk = 0, rst = 1, we = 0, re = 0, cmd = 0, rend = 0, xr = 0;
  logic [1:0] a = 0;
  logic [7:0] wd = 0, rdd;
  logic go, dma, nd, fd, pa, irq, st, dir, hl, t0;
  logic [4:0] thr;
  int fails = 0, n_checks = 0, nst = 0;
  always #10 clk = ~clk;
  always @(posedge st) nst++;
  // Short time unit keeps the long delays affordable
  fdccmd_top #(.UNIT_CYC_1M(4)) uut (.sys_clk_i(clk), .rst_i(rst), .addr_i(a),
    .wr_data_i(wd), .wr_i(we), .rd_i(re), .rd_data_o(rdd), .rw_cmd_i(cmd),
    .rw_cyl_i(8'h00), .rw_end_i(rend), .xfer_req_i(xr), .rw_go_o(go),
    .dma_request_pin_o(dma), .no_dma_select_o(nd), .fifo_disable_o(fd),
    .fifo_threshold_o(thr), .precomp_active_o(pa), .controller_interrupt_pin_o(irq),
    .track_zero_sense_i(t0), .write_protect_i(1'b0), .drive_ready_i(1'b1),
    .two_sided_i(1'b0), .step_o(st), .step_heading_in_o(dir), .head_load_o(hl),
    .drive_sel_o());
  fdccmd_drive_model drv (.step_i(st), .dir_i(dir), .trk0_o(t0));
  task finish_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [1:0] ad, input logic [7:0] d);
    @(posedge clk); a <= ad; wd <= d; we <= 1;
    @(posedge clk); we <= 0;
  endtask : wr
  task rd(input logic [1:0] ad, input logic [7:0] e);
    @(posedge clk); a <= ad; re <= 1;
    @(posedge clk); re <= 0;
    #1 chk("rd_data", rdd, e);
  endtask : rd
  // Bounded wait: 0 interrupt, 1 start pulse, 2 head unloaded
  task wt(input int k);
    int i;
    for (i = 0; i < 40000 && !(k == 0 ? irq : k == 1 ? go : !hl); i++) begin
      @(posedge clk); #1;
    end
    if (i == 40000) begin fails++; finish_test; end
  endtask : wt
  task sn(input logic [7:0] s0, input logic [7:0] p);
    wr(0, OP_SENSE_INT); rd(0, s0); rd(0, p);
  endtask : sn
  task sk(input logic [7:0] b0, b2, ns, s0, p);
    nst = 0; wr(0, b0); wr(0, 8'h00);
    if (b0 != OP_RECAL) wr(0, b2);
    wt(0); chk("steps", nst[7:0], ns); sn(s0, p);
  endtask : sk
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    #1 chk("irq", irq, 1);
    chk("fifo_dis", fd, 1);
    chk("thr", thr, 1);
    chk("precomp", pa, 1);
    chk("no_dma", nd, 0);
    sn(8'hC0, 8'h00);
    chk("irq", irq, 0);
    wr(3, 8'hFF); rd(3, 8'h00); wr(2, {6'h00, RATE_1M});
    wr(0, OP_VERSION); rd(0, 8'hA5);
    wr(0, OP_SENSE_DRV); wr(0, 8'h00); rd(0, 8'h20);
    wr(0, OP_SPECIFY); wr(0, 8'hF0); wr(0, 8'h03);
    wr(0, OP_CONFIGURE); wr(0, 8'h00); wr(0, 8'h07); wr(0, 8'h05);
    repeat (3) @(posedge clk);
    #1 chk("no_dma", nd, 1);
    chk("thr", thr, 8'h08);
    sk(8'hCF, 8'h05, 8'h05, 8'h20, 8'h05);
    chk("precomp", pa, 1);
    sk(8'hCF, 8'hFC, 8'hFC, 8'h20, 8'h01);
    sk(8'h8F, 8'h03, 8'h01, 8'h70, 8'h00);
    sk(OP_RECAL, 8'h00, 8'h50, 8'h70, 8'h00);
    sk(8'h0F, 8'h02, 8'h02, 8'h20, 8'h02);
    @(posedge clk); cmd <= 1;
    @(posedge clk); cmd <= 0; xr <= 1;
    wt(1); chk("head", hl, 1);
    chk("irq", irq, 1);
    chk("dma", dma, 0);
    @(posedge clk); xr <= 0; rend <= 1;
    @(posedge clk); rend <= 0;
    repeat (1000) @(posedge clk);
    #1 chk("head", hl, 1);
    wt(2);
    wr(0, OP_SPECIFY); wr(0, 8'hF0); wr(0, 8'h02);
    @(posedge clk); cmd <= 1;
    @(posedge clk); cmd <= 0; xr <= 1;
    wt(1); @(posedge clk);
    #1 chk("dma", dma, 1);
    finish_test;
  end
endmodule : fdccmd_top_tb
